// ==== common/dbg_glue_pkg.sv ====
package dbg_glue_pkg;
  // ==========================================
  // Area-0 address windows
  localparam int ADDR_W = 26;
  localparam logic [25:0] OPEN_FLASH_BASE = 26'h0000000;
  localparam logic [25:0] OPEN_EPROM_BASE = 26'h1000000;
  localparam logic [25:0] OPEN_NET_BASE = 26'h1400000;
  localparam logic [25:0] OPEN_LED_BASE = 26'h1800000;
  localparam logic [25:0] SHORT_EPROM_BASE = 26'h0000000;
  localparam logic [25:0] SHORT_NET_BASE = 26'h0400000;
  localparam logic [25:0] SHORT_LED_BASE = 26'h0800000;
  localparam logic [25:0] SHORT_FLASH_BASE = 26'h1000000;
  localparam int SMALL_WIN_LSB = 22;
  localparam int FLASH_WIN_LSB = 24;
  // ==========================================
  // Waits and configuration
  localparam int WAIT_SW_W = 4;
  localparam int NET_IRQ_LINES = 4;
  localparam logic [2:0] WAIT_FALLBACK = 3'h1;
  localparam logic [2:0] WAIT_NORMAL = 3'h0;
  localparam int LED_W = 8;
  localparam logic [7:0] LED_RESET = 8'hFF;
  // ==========================================
  // Register map
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_LED = 8'h08;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  localparam int CTRL_FREEZE_BIT = 0;
  localparam int ST_REGION_BIT = 8;
  localparam int ST_SLOW_BIT = 9;
  localparam int ST_WAIT_LSB = 12;
  localparam int ST_ROUTE_LSB = 16;
  localparam int ST_BUSY_BIT = 20;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [1:0] {
    DG_IDLE,
    DG_WAIT,
    DG_HOLD
  } dg_cycle_t;
endpackage

// ==== verilog/dbg_glue.sv ====
`timescale 1ns/1ps
`default_nettype none
module dbg_glue import dbg_glue_pkg::*; (
  input wire logic clk, // Processor bus clock output
  input wire logic rstn, // Synchronous reset, active low
  input wire logic busCsN, // Area-0 select from host
  input wire logic busRdN, // Read strobe
  input wire logic busWeN, // Write strobe
  input wire logic [ADDR_W-1:0] busAddr, // Host address
  input wire logic [7:0] lowDataByte, // Data bits 7..0
  output logic busWaitN, // Wait to host, low stalls
  output logic flashCeN, // Board flash enable
  output logic epromCeN, // EPROM enable
  output logic netCsN, // Network controller select
  output logic [LED_W-1:0] ledN, // LED drive, low is lit
  output logic expClkEn, // Expansion bus clock tick
  input wire logic netIrq, // Network controller interrupt pin
  output logic [NET_IRQ_LINES-1:0] extIrq, // External interrupt lines
  input wire logic regionSelectJumper, // High when shorted
  input wire logic [NET_IRQ_LINES-1:0] netIrqRouteJumper, // a..d, high when shorted
  input wire logic busSpeedSwitch, // High when on (low speed)
  input wire logic [WAIT_SW_W-1:0] waitCycleSwitch, // High when on
  input wire logic [7:0] s_axi_awaddr, // AXI write address
  input wire logic s_axi_awvalid, // AXI write address valid
  output logic s_axi_awready, // AXI write address ready
  input wire logic [31:0] s_axi_wdata, // AXI write data
  input wire logic [3:0] s_axi_wstrb, // AXI byte enables
  input wire logic s_axi_wvalid, // AXI write data valid
  output logic s_axi_wready, // AXI write data ready
  output logic [1:0] s_axi_bresp, // AXI write response
  output logic s_axi_bvalid, // AXI write response valid
  input wire logic s_axi_bready, // AXI response ready
  input wire logic [7:0] s_axi_araddr, // AXI read address
  input wire logic s_axi_arvalid, // AXI read address valid
  output logic s_axi_arready, // AXI read address ready
  output logic [31:0] s_axi_rdata, // AXI read data
  output logic [1:0] s_axi_rresp, // AXI read response
  output logic s_axi_rvalid, // AXI read valid
  input wire logic s_axi_rready // AXI read ready
);

  // ==========================================
  // Pin synchronisers
  localparam int SYNC_W = 2 + WAIT_SW_W + NET_IRQ_LINES + 1;
  logic [SYNC_W-1:0] syncA_r;
  logic [SYNC_W-1:0] syncB_r;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      syncA_r <= '0;
      syncB_r <= '0;
    end else begin
      syncA_r <= {netIrq, regionSelectJumper, busSpeedSwitch,
                  waitCycleSwitch, netIrqRouteJumper};
      syncB_r <= syncA_r;
    end
  end

  logic irqS;
  logic regionS;
  logic slowS;
  logic [WAIT_SW_W-1:0] waitS;
  logic [NET_IRQ_LINES-1:0] routeS;
  assign {irqS, regionS, slowS, waitS, routeS} = syncB_r;

  // ==========================================
  // Configuration snapshot
  logic [31:0] ctrl_r;
  logic region_r;
  logic slow_r;
  logic [2:0] waitSel_r;
  logic [2:0] waitSelNxt;
  dg_cycle_t state_r;

  always_comb begin
    unique case (waitS)
      4'h1: waitSelNxt = 3'h1;
      4'h2: waitSelNxt = 3'h2;
      4'h4: waitSelNxt = 3'h3;
      4'h8: waitSelNxt = 3'h4;
      default: waitSelNxt = WAIT_FALLBACK;
    endcase
    if (!slowS) begin
      waitSelNxt = WAIT_NORMAL;
    end
  end

  // Only reloaded between accesses, so a moving switch never bends a cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      region_r <= 1'b0;
      slow_r <= 1'b0;
      waitSel_r <= WAIT_NORMAL;
    end else if (state_r == DG_IDLE && busCsN && !ctrl_r[CTRL_FREEZE_BIT]) begin
      region_r <= regionS;
      slow_r <= slowS;
      waitSel_r <= waitSelNxt;
    end
  end

  // ==========================================
  // Expansion clock divider
  logic half_r;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      half_r <= 1'b0;
    end else begin
      half_r <= ~half_r;
    end
  end

  assign expClkEn = slow_r ? half_r : 1'b1;

  // ==========================================
  // Area-0 decoder
  logic hitFlash;
  logic hitEprom;
  logic hitNet;
  logic hitLed;
  logic [3:0] winIdx;

  // Small windows are 4 MB, so the top four address bits pick one
  assign winIdx = busAddr[ADDR_W-1:SMALL_WIN_LSB];

  always_comb begin
    if (!region_r) begin
      hitFlash = busAddr[ADDR_W-1:FLASH_WIN_LSB]
        == OPEN_FLASH_BASE[ADDR_W-1:FLASH_WIN_LSB];
      hitEprom = winIdx == OPEN_EPROM_BASE[ADDR_W-1:SMALL_WIN_LSB];
      hitNet = winIdx == OPEN_NET_BASE[ADDR_W-1:SMALL_WIN_LSB];
      hitLed = winIdx == OPEN_LED_BASE[ADDR_W-1:SMALL_WIN_LSB];
    end else begin
      hitEprom = winIdx == SHORT_EPROM_BASE[ADDR_W-1:SMALL_WIN_LSB];
      hitNet = winIdx == SHORT_NET_BASE[ADDR_W-1:SMALL_WIN_LSB];
      hitLed = winIdx == SHORT_LED_BASE[ADDR_W-1:SMALL_WIN_LSB];
      hitFlash = busAddr[ADDR_W-1:FLASH_WIN_LSB]
        == SHORT_FLASH_BASE[ADDR_W-1:FLASH_WIN_LSB];
    end
  end

  logic sel;
  assign sel = !busCsN;
  assign flashCeN = !(sel && hitFlash);
  // LED window is read back as EPROM
  assign epromCeN = !(sel && (hitEprom || (hitLed && !busRdN)));
  assign netCsN = !(sel && hitNet);

  // ==========================================
  // Access sequencer and wait inserter
  logic [2:0] waitCnt_r;
  logic csPrev_r;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      csPrev_r <= 1'b1;
    end else begin
      csPrev_r <= busCsN;
    end
  end

  // Waits are counted in expansion clock ticks, so low speed doubles them
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= DG_IDLE;
      waitCnt_r <= '0;
    end else begin
      unique case (state_r)
        DG_IDLE: begin
          if (csPrev_r && !busCsN) begin
            waitCnt_r <= waitSel_r;
            state_r <= (waitSel_r != 3'h0) ? DG_WAIT : DG_HOLD;
          end
        end
        DG_WAIT: begin
          if (expClkEn) begin
            waitCnt_r <= waitCnt_r - 3'h1;
            if (waitCnt_r == 3'h1) begin
              state_r <= DG_HOLD;
            end
          end
        end
        DG_HOLD: begin
          if (busCsN) begin
            state_r <= DG_IDLE;
          end
        end
      endcase
    end
  end

  assign busWaitN = !(state_r == DG_WAIT ||
                      (state_r == DG_IDLE && csPrev_r && !busCsN && waitSel_r != 3'h0));

  // ==========================================
  // LED latch
  logic [LED_W-1:0] led_r;
  logic swLedWr;
  logic [31:0] wdata_r;

  // Host is trusted to write a 16-bit word so bits 7..0 are driven
  always_ff @(posedge clk) begin
    if (!rstn) begin
      led_r <= LED_RESET;
    end else if (sel && hitLed && !busWeN && csPrev_r) begin
      led_r <= lowDataByte;
    end else if (swLedWr) begin
      led_r <= wdata_r[LED_W-1:0];
    end
  end

  assign ledN = led_r;

  // ==========================================
  // Interrupt routing
  logic [NET_IRQ_LINES-1:0] extIrq_r;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      extIrq_r <= '0;
    end else begin
      extIrq_r <= routeS & {NET_IRQ_LINES{irqS}};
    end
  end

  assign extIrq = extIrq_r;

  // ==========================================
  // AXI4-Lite slave
  logic awHeld_r;
  logic wHeld_r;
  logic [7:0] awaddr_r;
  logic [3:0] wstrb_r;
  logic doWrite;

  assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_r && !s_axi_bvalid;
  assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      awHeld_r <= 1'b0;
      awaddr_r <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wHeld_r <= 1'b0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeld_r <= 1'b0;
    end
  end

  assign swLedWr = doWrite && awaddr_r == REG_LED && wstrb_r[0];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_r <= CTRL_RESET;
    end else if (doWrite && awaddr_r == REG_CTRL && wstrb_r[0]) begin
      ctrl_r <= {31'h0, wdata_r[CTRL_FREEZE_BIT]};
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awaddr_r == REG_CTRL || awaddr_r == REG_LED)
                     ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic [31:0] status;
  always_comb begin
    status = 32'h00000000;
    status[LED_W-1:0] = led_r;
    status[ST_REGION_BIT] = region_r;
    status[ST_SLOW_BIT] = slow_r;
    status[ST_WAIT_LSB +: 3] = waitSel_r;
    status[ST_ROUTE_LSB +: NET_IRQ_LINES] = routeS;
    status[ST_BUSY_BIT] = state_r != DG_IDLE;
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      unique case (s_axi_araddr)
        REG_STATUS: s_axi_rdata <= status;
        REG_CTRL: s_axi_rdata <= ctrl_r;
        REG_LED: s_axi_rdata <= {24'h0, led_r};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= RESP_DECERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // dbg_glue
`default_nettype wire

// ==== bench/dbg_glue_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module dbg_glue_asserts import dbg_glue_pkg::*; (
  input wire logic clk, // Clock
  input wire logic rstn, // Reset
  input wire logic busCsN, // Select
  input wire logic busRdN, // Read
  input wire logic busWeN, // Write
  input wire logic [ADDR_W-1:0] busAddr, // Address
  input wire logic [7:0] lowDataByte, // Data
  input wire logic busWaitN, // Wait
  input wire logic flashCeN, // Flash
  input wire logic epromCeN, // EPROM
  input wire logic netCsN, // Network
  input wire logic [LED_W-1:0] ledN, // LEDs
  input wire logic expClkEn, // Tick
  input wire logic netIrq, // Interrupt
  input wire logic [NET_IRQ_LINES-1:0] extIrq, // Lines
  input wire logic regionSelectJumper, // Region
  input wire logic [NET_IRQ_LINES-1:0] netIrqRouteJumper, // Route
  input wire logic busSpeedSwitch, // Speed
  input wire logic [WAIT_SW_W-1:0] waitCycleSwitch // Waits
);
  // ==========
  // Checks
  wire logic [3:0] win = busAddr[25:22];
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Settings are trusted only once steady well past their synchronisers
  sequence s_open; (!regionSelectJumper)[*8]; endsequence
  sequence s_shrt; regionSelectJumper[*8]; endsequence
  sequence s_fast; (!busSpeedSwitch)[*8]; endsequence
  sequence s_slow; busSpeedSwitch[*8]; endsequence
  property p_dec_open; s_open ##0 !busCsN |-> {flashCeN, netCsN} == {win > 3, win != 5};
  endproperty
  a_dec_open: assert property (p_dec_open) else $error("open decode");
  property p_dec_shrt; s_shrt ##0 !busCsN |-> {flashCeN, netCsN} == {win[3:2] != 1, win != 1};
  endproperty
  a_dec_shrt: assert property (p_dec_shrt) else $error("shorted decode");
  property p_led; s_open ##0 !busCsN && !busWeN && win == 6 |=> ledN == $past(lowDataByte);
  endproperty
  a_led: assert property (p_led) else $error("led latch");
  property p_led_rd; s_open ##0 !busCsN && !busRdN && win == 6 |-> !epromCeN ##1 $stable(ledN);
  endproperty
  a_led_rd: assert property (p_led_rd) else $error("led read");
  property p_irq; ($stable(netIrq) && $stable(netIrqRouteJumper))[*6] |->
    extIrq == (netIrq ? netIrqRouteJumper : 4'h0);
  endproperty
  a_irq: assert property (p_irq) else $error("irq route");
  property p_fast; s_fast |-> expClkEn;
  endproperty
  a_fast: assert property (p_fast) else $error("normal tick");
  property p_slow; s_slow |-> expClkEn != $past(expClkEn);
  endproperty
  a_slow: assert property (p_slow) else $error("half tick");
  property p_nowait; s_fast ##0 $fell(busCsN) |-> busWaitN;
  endproperty
  a_nowait: assert property (p_nowait) else $error("wait at normal speed");
  property p_wait1; (busSpeedSwitch && $countones(waitCycleSwitch) != 1)[*8] ##0
    $fell(busCsN) |-> !busWaitN ##[1:4] busWaitN;
  endproperty
  a_wait1: assert property (p_wait1) else $error("fallback wait");
  property p_wait4; (busSpeedSwitch && waitCycleSwitch == 4'h8)[*8] ##0
    $fell(busCsN) |-> !busWaitN[*7];
  endproperty
  a_wait4: assert property (p_wait4) else $error("four waits");
endmodule // dbg_glue_asserts
bind dbg_glue dbg_glue_asserts i_chk(.*);
`default_nettype wire

// ==== bench/dbg_glue_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module dbg_glue_host import dbg_glue_pkg::*; (
  input wire logic clk, // Clock
  input wire logic busWaitN, // Wait
  output logic busCsN, // Select
  output logic busRdN, // Read
  output logic busWeN, // Write
  output logic [ADDR_W-1:0] busAddr, // Address
  output logic [7:0] lowDataByte // Data
);
  // ==========
  // Host cycle
  initial {busCsN, busRdN, busWeN, busAddr, lowDataByte} = '1;
  // Called just after an edge; w counts edges sampled up to the answer
  task automatic acc(input logic r, input logic [ADDR_W-1:0] a, input logic [7:0] d,
    output int w);
    busCsN <= 1'b0;
    busRdN <= !r;
    busWeN <= r;
    busAddr <= a;
    lowDataByte <= d; // Word access keeps the low byte valid
    w = 0;
    do begin
      @(posedge clk);
      w++;
    end while (!busWaitN && w < 40);
    busCsN <= 1'b1;
    busRdN <= 1'b1;
    busWeN <= 1'b1;
    // Released lines flip so a stale value never looks fresh
    busAddr <= ~a;
    lowDataByte <= ~d;
    @(posedge clk);
  endtask
endmodule // dbg_glue_host
`default_nettype wire

// ==== bench/dbg_glue_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module dbg_glue_test import dbg_glue_pkg::*;;
  // ==========
  // Stimulus and model
  logic clk = 1'b0, rstn = 1'b0, netIrq = 1'b0, regionSelectJumper = 1'b0;
  logic busSpeedSwitch = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0] netIrqRouteJumper = 4'h1, waitCycleSwitch = 4'h0, s_axi_wstrb = 4'hF, extIrq;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, lowDataByte, ledN, rnd = 8'h47;
  logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, rd;
  logic busCsN, busRdN, busWeN, busWaitN, flashCeN, epromCeN, netCsN, expClkEn;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [ADDR_W-1:0] busAddr;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [2:0] sel;
  int failures = 0, check_count = 0, w, ledM = 255;
  always #5 clk = ~clk;
  dbg_glue i_dut(.*);
  dbg_glue_host i_host(.*);
  function automatic logic [7:0] lf(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  function automatic logic [2:0] dec(input logic j, input logic r, input logic [25:0] a);
    int m;
    m = a[25:22];
    if (!j) return ~{m < 4, m == 4 || (r && m == 6), m == 5};
    return ~{m inside {[4:7]}, m == 0 || (r && m == 2), m == 1};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic results();
    if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic bus(input logic r, input logic [25:0] a, input int nw);
    fork
      i_host.acc(r, a, rnd, w);
      begin
        @(posedge clk);
        sel = {flashCeN, epromCeN, netCsN};
      end
    join
    if (w >= 40) begin
      failures++;
      results();
    end
    if (!r && a[25:22] == (regionSelectJumper ? 4'h2 : 4'h6)) ledM = rnd;
    chk("select", dec(regionSelectJumper, r, a), sel);
    chk("led", ledM, ledN);
    chk("waits", 1, nw ? (w >= 2 * nw && w <= 2 * nw + 2) : w == 1);
    rnd = lf(rnd);
  endtask
  task automatic ax(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_bvalid || s_axi_rvalid) break;
    end
    if (i == 40) begin
      failures++;
      results();
    end
    rd = s_axi_rdata;
    rs = wr ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask
  initial begin
    logic [25:0] ad [12];
    logic [3:0] ws [7];
    ad = '{26'h0, 26'h3FFFFE, 26'h400000, 26'h800000, 26'hFFFFFE, 26'h1000000,
      26'h13FFFFE, 26'h1400000, 26'h1800000, 26'h1BFFFFE, 26'h1C00000, 26'h3FFFFFE};
    ws = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h0, 4'h6};
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    chk("ledreset", LED_RESET, ledN);
    ax(1'b0, REG_CTRL, 0);
    chk("ctrl", CTRL_RESET, rd);
    waitCycleSwitch <= 4'h8;
    for (int j = 0; j < 2; j++) begin
      regionSelectJumper <= j[0];
      repeat (12) @(posedge clk);
      foreach (ad[k]) bus(1'b1, ad[k], 0);
      bus(1'b0, 26'h1800000, 0);
      bus(1'b0, 26'h0BFFFFE, 0);
    end
    busSpeedSwitch <= 1'b1;
    foreach (ws[k]) begin
      waitCycleSwitch <= ws[k];
      repeat (12) @(posedge clk);
      bus(1'b1, 26'h0400000, $countones(ws[k]) == 1 ? $clog2(ws[k]) + 1 : 1);
    end
    // Speed switch drops mid-access; the access keeps its slow wait
    fork
      bus(1'b1, 26'h0400000, 1);
      begin
        @(posedge clk);
        busSpeedSwitch <= 1'b0;
      end
    join
    repeat (3) begin
      netIrqRouteJumper <= rnd[3:0];
      netIrq <= 1'b1;
      repeat (6) @(posedge clk);
      chk("irq", rnd[3:0], extIrq);
      netIrq <= 1'b0;
      repeat (6) @(posedge clk);
      chk("irqoff", 0, extIrq);
      rnd = lf(rnd);
    end
    ax(1'b1, REG_LED, {24'h0, rnd});
    chk("bresp", RESP_OKAY, rs);
    chk("axiled", rnd, ledN);
    ax(1'b1, REG_CTRL, 1);
    ax(1'b0, REG_CTRL, 0);
    chk("ctrl", 1, rd);
    ax(1'b1, REG_CTRL, 0);
    ax(1'b0, 8'h0C, 0);
    chk("rresp", RESP_DECERR, rs);
    ax(1'b1, 8'h0C, 0);
    chk("bresp", RESP_DECERR, rs);
    results();
  end
endmodule // dbg_glue_test
`default_nettype wire
